// [src/fdd_host.sv]
// Host-side controller that drives an 8-inch flexible disk drive pins.
// Assumes the drive pins are asynchronous; all are double synchronised.
// Functional notes
// - Direction is held stable from before step until 200 ns after.
// - Each step is one active-low 10 us pulse moving one track.
// - Head load is asserted at least 50 ms before read or write.
// - One 200 ns active-low write pulse per flux reversal.
// - Low current is asserted when writing tracks 48 through 76.
// - No read or write until two seconds after power-up.
// - Step outward until track zero before any read or write.
// - Read is head load with write gate inactive.
module fdd_host #(
  parameter int unsigned POWERUP_CYC  = fdd_host_pkg::POWERUP_CYC,
  parameter int unsigned LOAD_CYC     = fdd_host_pkg::LOAD_CYC,
  parameter int unsigned SETTLE_CYC   = fdd_host_pkg::SETTLE_CYC,
  parameter int unsigned STEP_GAP_CYC = fdd_host_pkg::STEP_GAP_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [1:0] cmd_op_i,
  input  wire logic [1:0] cmd_drive_i,
  input  wire logic [6:0] cmd_track_i,
  output logic            cmd_ready_o,
  input  wire logic       xfer_stop_i,
  input  wire logic       wr_pulse_valid_i,
  output logic            wr_pulse_ready_o,
  output logic            rd_pulse_o,
  output logic            index_pulse_o,
  output logic            done_o,
  output logic            err_o,
  output logic            homed_o,
  output logic            power_ok_o,
  output logic [6:0]      track_o,
  output logic            disk_ready_o,
  output logic            present_o,
  output logic            dir_in_b_o,
  output logic            step_b_o,
  output logic            head_load_b_o,
  output logic [3:0]      sel_o,
  output logic            wr_gate_b_o,
  output logic            wr_flux_b_o,
  output logic            erase_b_o,
  output logic            low_cur_b_o,
  input  wire logic       index_b_i,
  input  wire logic       trk0_b_i,
  input  wire logic       rd_flux_b_i,
  input  wire logic       ready_b_i,
  input  wire logic       present_b_i
);

  localparam int unsigned NP = fdd_host_pkg::PIN_COUNT;

  typedef enum logic [3:0] {
    ST_POWER, ST_IDLE, ST_DIR, ST_STEP, ST_GAP, ST_SETTLE, ST_LOAD, ST_XFER
  } state_t;

  // Pin synchronisers; the third stage only feeds edge detection.
  logic [NP-1:0] sync1_reg, sync2_reg, prev_reg;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      prev_reg  <= '1;
    end else begin
      sync1_reg <= {present_b_i, ready_b_i, rd_flux_b_i, trk0_b_i, index_b_i};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic trk0_on, ready_on;
  assign trk0_on  = !sync2_reg[fdd_host_pkg::PIN_TRK0];
  assign ready_on = !sync2_reg[fdd_host_pkg::PIN_READY];

  state_t      state_reg, state_next;
  logic [31:0] timer_reg, timer_next;
  logic [6:0]  track_reg, track_next, target_reg, target_next;
  logic [1:0]  drive_reg, drive_next;
  logic        wr_mode_reg, wr_mode_next, recal_reg, recal_next;
  logic        extra_reg, extra_next, homed_reg, homed_next;
  logic        inward_reg, inward_next;
  logic        done_reg, done_next, err_reg, err_next;
  logic [2:0]  flux_cnt_reg, flux_cnt_next;
  logic        step_b_next, load_b_next, gate_b_next, low_b_next;
  logic        busy_next;
  logic [3:0]  sel_next;
  logic        rd_next, idx_next;

  localparam logic [2:0] FLUX_START = 3'(fdd_host_pkg::FLUX_W_CYC + 1);

  always_comb begin
    state_next   = state_reg;
    timer_next   = timer_reg + 32'h1;
    track_next   = track_reg;
    target_next  = target_reg;
    drive_next   = drive_reg;
    wr_mode_next = wr_mode_reg;
    recal_next   = recal_reg;
    extra_next   = extra_reg;
    homed_next   = homed_reg;
    inward_next  = inward_reg;
    done_next    = 1'b0;
    err_next     = 1'b0;
    unique case (state_reg)
      ST_POWER: if (timer_reg >= 32'(POWERUP_CYC - 1)) begin
        state_next = ST_IDLE;
      end
      ST_IDLE: begin
        timer_next = 32'h0;
        if (cmd_valid_i) begin
          drive_next = cmd_drive_i;
          unique case (fdd_host_pkg::op_t'(cmd_op_i))
            fdd_host_pkg::OP_RECAL: begin
              recal_next  = 1'b1;
              extra_next  = 1'b0;
              homed_next  = 1'b0;
              inward_next = 1'b0;
              target_next = 7'h0;
              state_next  = ST_DIR;
            end
            fdd_host_pkg::OP_SEEK: begin
              if (!homed_reg || cmd_track_i > fdd_host_pkg::TRACK_LAST) begin
                err_next = 1'b1;
              end else if (cmd_track_i == track_reg) begin
                done_next = 1'b1;
              end else begin
                recal_next  = 1'b0;
                target_next = cmd_track_i;
                inward_next = cmd_track_i > track_reg;
                state_next  = ST_DIR;
              end
            end
            default: begin
              if (!homed_reg) begin
                err_next = 1'b1;
              end else begin
                wr_mode_next = cmd_op_i == 2'(fdd_host_pkg::OP_WRITE);
                state_next   = ST_LOAD;
              end
            end
          endcase
        end
      end
      ST_DIR: if (timer_reg >= 32'(fdd_host_pkg::DIR_SETUP_CYC - 1)) begin
        timer_next = 32'h0;
        state_next = ST_STEP;
      end
      ST_STEP: if (timer_reg >= 32'(fdd_host_pkg::STEP_W_CYC - 1)) begin
        timer_next = 32'h0;
        state_next = ST_GAP;
        if (inward_reg) begin
          track_next = track_reg + 7'h1;
        end else if (track_reg != 7'h0) begin
          track_next = track_reg - 7'h1;
        end
        if (recal_reg) begin
          target_next = target_reg + 7'h1;
        end
      end
      ST_GAP: if (timer_reg >= 32'(STEP_GAP_CYC - 1)) begin
        timer_next = 32'h0;
        if (!recal_reg && track_reg != target_reg) begin
          state_next = ST_DIR;
        end else begin
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: if (timer_reg >= 32'(SETTLE_CYC - 1)) begin
        timer_next = 32'h0;
        state_next = ST_IDLE;
        if (!recal_reg) begin
          done_next = 1'b1;
        end else if (extra_reg) begin
          // The flag also covers track 01, so one more outward step
          // is issued; the drive ignores it at track 00.
          homed_next = 1'b1;
          track_next = 7'h0;
          done_next  = 1'b1;
        end else if (trk0_on) begin
          extra_next = 1'b1;
          state_next = ST_DIR;
        end else if (target_reg >= fdd_host_pkg::RECAL_LIMIT) begin
          err_next = 1'b1;
        end else begin
          state_next = ST_DIR;
        end
      end
      ST_LOAD: if (timer_reg >= 32'(LOAD_CYC - 1)) begin
        // A deselected drive shows no ready, so the disk is judged here.
        if (ready_on) begin
          state_next = ST_XFER;
        end else begin
          err_next   = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_XFER: begin
        if (!ready_on) begin
          err_next   = 1'b1;
          state_next = ST_IDLE;
        end else if (xfer_stop_i && flux_cnt_reg == 3'h0) begin
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    busy_next   = state_next != ST_IDLE && state_next != ST_POWER;
    step_b_next = state_next != ST_STEP;
    load_b_next = !(state_next == ST_LOAD || state_next == ST_XFER);
    // Writing and stepping never overlap: the gate is only open in XFER.
    gate_b_next = !(state_next == ST_XFER && wr_mode_next);
    low_b_next  = gate_b_next || track_next < fdd_host_pkg::TRACK_LOW_CUR;
    sel_next    = busy_next ? 4'h1 << drive_next : 4'h0;
  end

  // Write flux pulses: low for the pulse width, then at least one high.
  assign wr_pulse_ready_o = state_reg == ST_XFER && wr_mode_reg &&
                            flux_cnt_reg == 3'h0 && !wr_gate_b_o;
  always_comb begin
    flux_cnt_next = flux_cnt_reg;
    if (flux_cnt_reg != 3'h0) begin
      flux_cnt_next = flux_cnt_reg - 3'h1;
    end else if (wr_pulse_valid_i && wr_pulse_ready_o) begin
      flux_cnt_next = FLUX_START;
    end
    rd_next  = state_reg == ST_XFER && !wr_mode_reg &&
               prev_reg[fdd_host_pkg::PIN_RDATA] &&
               !sync2_reg[fdd_host_pkg::PIN_RDATA];
    idx_next = prev_reg[fdd_host_pkg::PIN_INDEX] &&
               !sync2_reg[fdd_host_pkg::PIN_INDEX];
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg     <= ST_POWER;
      timer_reg     <= 32'h0;
      track_reg     <= 7'h0;
      target_reg    <= 7'h0;
      drive_reg     <= 2'h0;
      wr_mode_reg   <= 1'b0;
      recal_reg     <= 1'b0;
      extra_reg     <= 1'b0;
      homed_reg     <= 1'b0;
      inward_reg    <= 1'b0;
      done_reg      <= 1'b0;
      err_reg       <= 1'b0;
      flux_cnt_reg  <= 3'h0;
      step_b_o      <= 1'b1;
      head_load_b_o <= 1'b1;
      wr_gate_b_o   <= 1'b1;
      erase_b_o     <= 1'b1;
      low_cur_b_o   <= 1'b1;
      wr_flux_b_o   <= 1'b1;
      dir_in_b_o    <= 1'b1;
      sel_o         <= 4'h0;
      rd_pulse_o    <= 1'b0;
      index_pulse_o <= 1'b0;
    end else begin
      state_reg     <= state_next;
      timer_reg     <= timer_next;
      track_reg     <= track_next;
      target_reg    <= target_next;
      drive_reg     <= drive_next;
      wr_mode_reg   <= wr_mode_next;
      recal_reg     <= recal_next;
      extra_reg     <= extra_next;
      homed_reg     <= homed_next;
      inward_reg    <= inward_next;
      done_reg      <= done_next;
      err_reg       <= err_next;
      flux_cnt_reg  <= flux_cnt_next;
      step_b_o      <= step_b_next;
      head_load_b_o <= load_b_next;
      wr_gate_b_o   <= gate_b_next;
      erase_b_o     <= gate_b_next;
      low_cur_b_o   <= low_b_next;
      wr_flux_b_o   <= !(flux_cnt_next > 3'h1);
      dir_in_b_o    <= !inward_next;
      sel_o         <= sel_next;
      rd_pulse_o    <= rd_next;
      index_pulse_o <= idx_next;
    end
  end

  assign cmd_ready_o  = state_reg == ST_IDLE;
  assign done_o       = done_reg;
  assign err_o        = err_reg;
  assign homed_o      = homed_reg;
  assign power_ok_o   = state_reg != ST_POWER;
  assign track_o      = track_reg;
  assign disk_ready_o = !sync2_reg[fdd_host_pkg::PIN_READY];
  assign present_o    = !sync2_reg[fdd_host_pkg::PIN_PRES];

  // Helper counters for the assertions below.
  logic [31:0] step_len_reg, load_len_reg;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_len_reg <= 32'h0;
      load_len_reg <= 32'h0;
    end else begin
      step_len_reg <= step_b_o ? 32'h0 : step_len_reg + 32'h1;
      load_len_reg <= head_load_b_o ? 32'h0 :
                      (load_len_reg == 32'hffffffff ? load_len_reg :
                       load_len_reg + 32'h1);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_step_width: assert property ($rose(step_b_o) |->
    step_len_reg == 32'(fdd_host_pkg::STEP_W_CYC))
    else $error("Step pulse width wrong.");
  a_dir_hold: assert property ($fell(step_b_o) |->
    $stable(dir_in_b_o) ##1 $stable(dir_in_b_o) ##1 $stable(dir_in_b_o))
    else $error("Direction changed around step edge.");
  a_no_step_write: assert property (!(!wr_gate_b_o && !step_b_o))
    else $error("Step issued while writing.");
  a_flux_width: assert property ($fell(wr_flux_b_o) |->
    !wr_flux_b_o ##1 !wr_flux_b_o ##1 wr_flux_b_o)
    else $error("Write flux pulse width wrong.");
  a_erase_with_write: assert property (erase_b_o == wr_gate_b_o)
    else $error("Erase gate differs from write gate.");
  a_low_current: assert property ((!wr_gate_b_o &&
    track_reg >= fdd_host_pkg::TRACK_LOW_CUR) |-> !low_cur_b_o)
    else $error("Low current missing on inner track.");
  a_load_lead: assert property ($fell(wr_gate_b_o) |->
    load_len_reg >= 32'(LOAD_CYC))
    else $error("Write began too soon after head load.");
  a_read_no_gate: assert property ($rose(rd_pulse_o) |-> wr_gate_b_o)
    else $error("Read pulse while write gate on.");
  a_sel_onehot: assert property (!step_b_o |-> $onehot(sel_o))
    else $error("Step without exactly one select.");
  a_homed_first: assert property ($fell(head_load_b_o) |->
    homed_reg && power_ok_o)
    else $error("Head loaded before homing or power wait.");

endmodule

// [include/fdd_host_pkg.sv]
// Shared constants for the flexible disk drive host controller.
// Assumes a single 10 MHz system clock; all times below are in their own
// unit and converted to clock cycles here.
package fdd_host_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  // Pin timing in ns.
  localparam int unsigned STEP_W_NS   = 10000;
  localparam int unsigned DIR_HOLD_NS = 200;
  localparam int unsigned FLUX_W_NS   = 200;

  // Mechanical timing in ms.
  localparam int unsigned LOAD_MS     = 50;
  localparam int unsigned SETTLE_MS   = 10;
  localparam int unsigned POWERUP_MS  = 2000;
  localparam int unsigned STEP_GAP_MS = 6;

  localparam int unsigned NS_PER_MS = 1000000;

  localparam int unsigned STEP_W_CYC =
    (STEP_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIR_SETUP_CYC =
    (DIR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLUX_W_CYC =
    (FLUX_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_CYC =
    LOAD_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned SETTLE_CYC =
    SETTLE_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned POWERUP_CYC =
    POWERUP_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned STEP_GAP_CYC =
    STEP_GAP_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // Track geometry.
  localparam logic [6:0] TRACK_LOW_CUR = 7'h30;
  localparam logic [6:0] TRACK_LAST    = 7'h4c;
  localparam logic [6:0] RECAL_LIMIT   = 7'h50;

  // Pin input positions in the synchroniser vector.
  localparam int unsigned PIN_INDEX = 0;
  localparam int unsigned PIN_TRK0  = 1;
  localparam int unsigned PIN_RDATA = 2;
  localparam int unsigned PIN_READY = 3;
  localparam int unsigned PIN_PRES  = 4;
  localparam int unsigned PIN_COUNT = 5;

  typedef enum logic [1:0] {
    OP_RECAL,
    OP_SEEK,
    OP_READ,
    OP_WRITE
  } op_t;

endpackage

// [verification/fdd_drive_model.sv]
// Behavioural model of one flexible disk drive on the controller's pins.
// Assumes one select bit addresses it; released outputs float high.
module fdd_drive_model #(
  parameter int      DRV_NUM  = 2,
  parameter int      TRK_INIT = 5,
  parameter realtime IDX_PER  = 300000.0,
  parameter realtime IDX_LOW  = 4500.0
) (
  input  wire logic [3:0] sel_i,
  input  wire logic       dir_in_b_i,
  input  wire logic       step_b_i,
  input  wire logic       head_load_b_i,
  input  wire logic       wr_gate_b_i,
  input  wire logic       wr_flux_b_i,
  input  wire logic       erase_b_i,
  input  wire logic       low_cur_b_i,
  input  wire logic       disk_ok_i,
  output logic            index_b_o,
  output logic            trk0_b_o,
  output logic            rd_flux_b_o,
  output logic            ready_b_o,
  output logic            present_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int      track    = TRK_INIT;
  int      flux_cnt = 0;
  int      viol     = 0;
  logic    idx_low  = 1'b0;
  logic    rd_low   = 1'b0;
  logic    wr_blk   = 1'b0;
  realtime t_step   = -1.0e6;
  realtime t_flux   = -1.0e6;
  wire sel_me = sel_i[DRV_NUM] === 1'b1;
  wire loaded = sel_me && !head_load_b_i && disk_ok_i;
  wire wr_on = loaded && !wr_gate_b_i && !wr_blk;
  wire erase_on = loaded && !erase_b_i;
  wire weak_wr = wr_on && !low_cur_b_i;
  assign index_b_o = !(sel_me && disk_ok_i && idx_low);
  assign trk0_b_o = !(sel_me && track <= 1);
  assign rd_flux_b_o = !(loaded && rd_low);
  assign ready_b_o = !(sel_me && disk_ok_i);
  assign present_b_o = !sel_me;
  initial forever begin
    #(IDX_PER - IDX_LOW) idx_low = 1'b1;
    #(IDX_LOW) idx_low = 1'b0;
  end
  always @(negedge step_b_i) begin
    t_step = $realtime;
    if (sel_me) begin
      wr_blk = !wr_gate_b_i;
      #100;
      if (dir_in_b_i === 1'b0) track = track + 1;
      else if (track > 0) track = track - 1;
    end
  end
  always @(posedge wr_gate_b_i) wr_blk = 1'b0;
  // Timing slips by the controller are only counted; the bench judges them.
  always @(posedge step_b_i) if ($realtime - t_step < 10000.0) viol++;
  always @(dir_in_b_i) if ($realtime - t_step < 200.0) viol++;
  always @(negedge wr_flux_b_i) begin
    t_flux = $realtime;
    if (wr_on) flux_cnt++;
    if (wr_on && track >= 48 && !weak_wr) viol++;
  end
  always @(posedge wr_flux_b_i) if ($realtime - t_flux < 200.0) viol++;
  task automatic sense();
    rd_low = 1'b1;
    #200;
    rd_low = 1'b0;
  endtask
endmodule

// [verification/fdd_host_tb_top.sv]
// Self-checking bench for the disk controller against the drive model.
// Assumes shortened power, load, settle and gap counts for a brief run.
module fdd_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PWR  = 40;
  localparam int LOAD = 20;
  logic       sys_clk_i        = 1'b0;
  logic       rst_b_i          = 1'b0;
  logic       cmd_valid_i      = 1'b0;
  logic [1:0] cmd_op_i         = 2'h0;
  logic [1:0] cmd_drive_i      = 2'h0;
  logic [6:0] cmd_track_i      = 7'h00;
  logic       xfer_stop_i      = 1'b0;
  logic       wr_pulse_valid_i = 1'b0;
  logic       disk_ok          = 1'b1;
  logic       cmd_ready_o, wr_pulse_ready_o, rd_pulse_o, index_pulse_o;
  logic       done_o, err_o, homed_o, power_ok_o, disk_ready_o, present_o;
  logic       dir_in_b_o, step_b_o, head_load_b_o, wr_gate_b_o;
  logic       wr_flux_b_o, erase_b_o, low_cur_b_o;
  logic       index_b_i, trk0_b_i, rd_flux_b_i, ready_b_i, present_b_i;
  logic [6:0] track_o;
  logic [3:0] sel_o;
  int         err_count = 0;
  int         num_checks = 0;
  int         n_rd = 0;
  int         n_idx = 0;

  fdd_host #(.POWERUP_CYC(PWR), .LOAD_CYC(LOAD), .SETTLE_CYC(10),
    .STEP_GAP_CYC(10)) dut (
    .sys_clk_i, .rst_b_i, .cmd_valid_i, .cmd_op_i, .cmd_drive_i,
    .cmd_track_i, .cmd_ready_o, .xfer_stop_i, .wr_pulse_valid_i,
    .wr_pulse_ready_o, .rd_pulse_o, .index_pulse_o, .done_o, .err_o,
    .homed_o, .power_ok_o, .track_o, .disk_ready_o, .present_o,
    .dir_in_b_o, .step_b_o, .head_load_b_o, .sel_o, .wr_gate_b_o,
    .wr_flux_b_o, .erase_b_o, .low_cur_b_o, .index_b_i, .trk0_b_i,
    .rd_flux_b_i, .ready_b_i, .present_b_i);

  fdd_drive_model mdl (
    .sel_i(sel_o), .dir_in_b_i(dir_in_b_o), .step_b_i(step_b_o),
    .head_load_b_i(head_load_b_o), .wr_gate_b_i(wr_gate_b_o),
    .wr_flux_b_i(wr_flux_b_o), .erase_b_i(erase_b_o),
    .low_cur_b_i(low_cur_b_o), .disk_ok_i(disk_ok),
    .index_b_o(index_b_i), .trk0_b_o(trk0_b_i),
    .rd_flux_b_o(rd_flux_b_i), .ready_b_o(ready_b_i),
    .present_b_o(present_b_i));

  always #50 sys_clk_i = ~sys_clk_i;

  always @(negedge sys_clk_i) begin
    if (rd_pulse_o === 1'b1) n_rd++;
    if (index_pulse_o === 1'b1) n_idx++;
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic issue(logic [1:0] op, logic [6:0] trk, logic [1:0] drv);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i    <= op;
    cmd_track_i <= trk;
    cmd_drive_i <= drv;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
  endtask

  task automatic finish_cmd(logic exp_err);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (done_o !== 1'b1 && err_o !== 1'b1 && n < 20000);
    chk("err_o", {31'h0, exp_err}, {31'h0, err_o});
    chk("done_o", {31'h0, !exp_err}, {31'h0, done_o});
  endtask

  task automatic run(logic [1:0] op, logic [6:0] trk, logic [1:0] drv,
                     logic exp_err);
    issue(op, trk, drv);
    finish_cmd(exp_err);
  endtask

  // Waits for the head load to assert and the head load time to pass.
  task automatic wait_xfer();
    int n;
    n = 0;
    while (head_load_b_o !== 1'b0 && n < 500) begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (LOAD + 5) @(negedge sys_clk_i);
  endtask

  task automatic stop_xfer();
    @(posedge sys_clk_i);
    xfer_stop_i <= 1'b1;
    finish_cmd(1'b0);
    @(posedge sys_clk_i);
    xfer_stop_i <= 1'b0;
  endtask

  task automatic t_power();
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < PWR + 50) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("power wait long enough", 1, n >= PWR);
    chk("power_ok_o", 1, power_ok_o);
  endtask

  task automatic t_write(logic [6:0] trk, logic exp_low_b);
    int f0;
    int n;
    int k;
    run(2'h1, trk, 2'h2, 1'b0);
    chk("track_o", trk, track_o);
    chk("drive track", trk, mdl.track);
    issue(2'h3, trk, 2'h2);
    wait_xfer();
    chk("head_load_b_o", 0, head_load_b_o);
    chk("wr_gate_b_o", 0, wr_gate_b_o);
    chk("erase_b_o", 0, erase_b_o);
    chk("low_cur_b_o", exp_low_b, low_cur_b_o);
    f0 = mdl.flux_cnt;
    n = 0;
    k = 0;
    @(posedge sys_clk_i);
    wr_pulse_valid_i <= 1'b1;
    while (n < 3 && k < 100) begin
      @(negedge sys_clk_i);
      k++;
      if (wr_pulse_ready_o === 1'b1) n++;
    end
    @(posedge sys_clk_i);
    wr_pulse_valid_i <= 1'b0;
    repeat (6) @(negedge sys_clk_i);
    chk("flux reversals", 3, mdl.flux_cnt - f0);
    stop_xfer();
    chk("head_load_b_o idle", 1, head_load_b_o);
  endtask

  task automatic t_read();
    int r0;
    int i0;
    issue(2'h2, 7'h2f, 2'h2);
    wait_xfer();
    chk("wr_gate_b_o", 1, wr_gate_b_o);
    chk("disk_ready_o", 1, disk_ready_o);
    chk("present_o", 1, present_o);
    chk("sel_o", 32'h4, sel_o);
    r0 = n_rd;
    mdl.sense();
    repeat (5) @(negedge sys_clk_i);
    mdl.sense();
    repeat (10) @(negedge sys_clk_i);
    chk("rd_pulse count", 2, n_rd - r0);
    i0 = n_idx;
    repeat (3000) @(negedge sys_clk_i);
    chk("index count", 1, n_idx - i0);
    stop_xfer();
  endtask

  initial begin
    #8000000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_power();
    run(2'h1, 7'h03, 2'h2, 1'b1);
    run(2'h0, 7'h00, 2'h1, 1'b1);
    chk("drive track unselected", 5, mdl.track);
    run(2'h0, 7'h00, 2'h2, 1'b0);
    chk("homed_o", 1, homed_o);
    chk("track_o", 0, track_o);
    chk("drive track home", 0, mdl.track);
    run(2'h1, 7'h4d, 2'h2, 1'b1);
    t_write(7'h30, 1'b0);
    t_write(7'h2f, 1'b1);
    t_read();
    disk_ok <= 1'b0;
    run(2'h2, 7'h2f, 2'h2, 1'b1);
    chk("head_load_b_o no disk", 1, head_load_b_o);
    chk("pin timing slips", 0, mdl.viol);
    finish_test();
  end
endmodule
